// file: sps_pkg.sv
// package of constants and carrier types for the serial port
package sps_pkg;
   localparam int      WORD_W       = 16;
   localparam int      FIFO_DEPTH   = 8;
   localparam int      BITS_BYTE    = 8;
   localparam int      BITS_WORD    = 16;
   localparam int      MSB_BYTE     = 7;
   localparam int      MSB_WORD     = 15;
   localparam int      LSB_IN       = 0;
   localparam int      CORE_DIV     = 4;
   localparam logic [4:0] CNT_ZERO  = 5'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [9:0] DIV_RST   = 10'h000;

   typedef enum logic [1:0] {
      SPS_IDLE  = 2'b00,
      SPS_FRAME = 2'b01,
      SPS_SHIFT = 2'b10
   } sps_state_t;

   typedef struct packed {
      logic       enable;
      logic       master;
      logic       word16;
      logic       cke;
      logic       clock_idle_polarity;
      logic       smp;
      logic       ss_en;
      logic       out_dis;
      logic       frm_en;
      logic       frm_in;
      logic       stop_idle;
      logic [1:0] pri_pre;
      logic [2:0] sec_pre;
   } sps_cfg_t;

   typedef struct packed {
      logic       xfer_done;
      logic       overflow;
      logic       tx_full;
      logic       rx_full;
      logic       irq;
   } sps_stat_t;
endpackage : sps_pkg

// file: sps_fifo.sv
// parameterised valid/ready fifo in the transmit data path
`timescale 1ns/1ns
module sps_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk_in,
   input  wire logic             nrst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;
   logic [AW:0]      cnt_d;
   logic             rdy_q;

   // ready comes from a flop so the port output is registered
   assign in_ready_out  = rdy_q;
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out  = mem[rd_q];
   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;
   assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b1;
      end else begin
         if (push) begin
            mem[wr_q] <= in_data_in;
            wr_q      <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_d;
         rdy_q <= (cnt_d != (AW+1)'(DEPTH));
      end
   end
endmodule : sps_fifo

// file: sps_port.sv
// serial peripheral port, master or slave, with frame and select support
`timescale 1ns/1ns
module sps_port (
   input  wire logic              core_clk_in,
   input  wire logic              nrst_in,
   input  wire sps_pkg::sps_cfg_t cfg_in,
   input  wire logic              xfer_irq_enable_in,
   input  wire logic              sleep_in,
   input  wire logic              cpu_idle_in,
   input  wire logic              buf_wr_in,
   input  wire logic [15:0]       buf_wdata_in,
   output logic                   buf_wr_ready_out,
   input  wire logic              buf_rd_in,
   output logic [15:0]            buf_rdata_out,
   input  wire logic              clr_done_in,
   input  wire logic              clr_ovf_in,
   output sps_pkg::sps_stat_t     stat_out,
   input  wire logic              shift_clock_pin_in,
   output logic                   shift_clock_pin_out,
   output logic                   shift_clock_pin_oe_n_out,
   input  wire logic              serial_in_pin_in,
   output logic                   serial_out_pin_out,
   output logic                   serial_out_pin_oe_n_out,
   input  wire logic              slave_select_n_pin_in,
   output logic                   slave_select_n_pin_out,
   output logic                   slave_select_n_pin_oe_n_out
);
   typedef struct packed {
      sps_pkg::sps_state_t st;
      logic [15:0] sr;
      logic [15:0] rxb;
      logic [4:0]  cnt;
      logic [9:0]  div;
      logic        sck;
      logic        sck_in;
      logic        ss_in;
      logic        rx_full;
      logic        ovf;
      logic        done;
      logic        irq;
      logic        width;
      logic        fs;
      logic        sdo;
      logic        sdo_oe_n;
      logic        sck_oe_n;
      logic        fs_oe_n;
      logic        loaded;
   } sps_regs_t;

   sps_regs_t r_q;
   sps_regs_t r_d;

   logic        tx_valid;
   logic        tx_pop;
   logic [15:0] tx_data;

   // transmit holding words queue behind the data address
   sps_fifo #(
      .WIDTH (sps_pkg::WORD_W),
      .DEPTH (sps_pkg::FIFO_DEPTH)
   ) u_txq (
      .core_clk_in   (core_clk_in),
      .nrst_in       (nrst_in),
      .in_valid_in   (buf_wr_in),
      .in_ready_out  (buf_wr_ready_out),
      .in_data_in    (buf_wdata_in),
      .out_valid_out (tx_valid),
      .out_ready_in  (tx_pop),
      .out_data_out  (tx_data)
   );

   // half period minus one in core cycles: 4/2 times primary times secondary
   function automatic logic [9:0] half_m1(input logic [1:0] p,
                                          input logic [2:0] s);
      logic [11:0] pf;
      logic [11:0] sf;
      logic [11:0] prod;
      pf      = 12'h040 >> {p, 1'b0};
      sf      = 12'(4'h8 - {1'b0, s});
      // the slowest setting gives 1024, so work wider than the counter
      prod    = (pf * sf * 12'(sps_pkg::CORE_DIV)) >> 1;
      half_m1 = 10'(prod - 12'h001);
   endfunction : half_m1

   function automatic logic [4:0] nbits(input logic w);
      nbits = w ? 5'(sps_pkg::BITS_WORD) : 5'(sps_pkg::BITS_BYTE);
   endfunction : nbits

   logic run;
   logic sel_ok;
   logic lead_edge;
   logic trail_edge;
   logic tx_edge;
   logic rx_edge;
   logic msb;
   logic last;
   logic [15:0] shifted;
   logic fin;

   always_comb begin
      r_d = r_q;
      tx_pop = 1'b0;
      fin = 1'b0;
      // sleep and stop-in-idle halt the port and abort the transfer, resetting state, count and divider
      run = cfg_in.enable & ~sleep_in
            & ~(cpu_idle_in & cfg_in.stop_idle);
      sel_ok = cfg_in.master | ~cfg_in.ss_en | cfg_in.frm_en
               | ~r_q.ss_in;
      r_d.sck_in = shift_clock_pin_in;
      r_d.ss_in  = slave_select_n_pin_in;
      lead_edge  = 1'b0;
      trail_edge = 1'b0;
      msb  = r_q.width ? r_q.sr[sps_pkg::MSB_WORD]
                       : r_q.sr[sps_pkg::MSB_BYTE];
      shifted = {r_q.sr[14:0], serial_in_pin_in};
      last = (r_q.cnt == nbits(r_q.width) - 5'h01);
      if (cfg_in.master) begin
         if (r_q.st != sps_pkg::SPS_IDLE) begin
            if (r_q.div == half_m1(cfg_in.pri_pre, cfg_in.sec_pre)) begin
               r_d.div = sps_pkg::DIV_RST;
               r_d.sck = ~r_q.sck;
               lead_edge  = (r_q.sck == cfg_in.clock_idle_polarity);
               trail_edge = ~lead_edge;
            end else begin
               r_d.div = r_q.div + 10'h001;
            end
         end else begin
            r_d.div = sps_pkg::DIV_RST;
            r_d.sck = cfg_in.clock_idle_polarity;
         end
      end else begin
         lead_edge  = (r_q.sck_in == cfg_in.clock_idle_polarity)
                      & (shift_clock_pin_in != cfg_in.clock_idle_polarity);
         trail_edge = (r_q.sck_in != cfg_in.clock_idle_polarity)
                      & (shift_clock_pin_in == cfg_in.clock_idle_polarity);
      end
      // cke=1 changes data leaving active level, so capture on leading edge
      tx_edge = cfg_in.cke ? trail_edge : lead_edge;
      rx_edge = cfg_in.cke ? lead_edge : trail_edge;
      // a read frees the buffer first, so a word completing now still lands
      if (buf_rd_in) begin
         r_d.rx_full = 1'b0;
         r_d.ovf = 1'b0;
      end
      r_d.fs = 1'b0;
      case (r_q.st)
         sps_pkg::SPS_IDLE: begin
            r_d.cnt = sps_pkg::CNT_ZERO;
            if (run & tx_valid & ~r_q.ovf & cfg_in.master) begin
               r_d.sr = tx_data;
               tx_pop = 1'b1;
               r_d.loaded = 1'b1;
               r_d.st = cfg_in.frm_en ? sps_pkg::SPS_FRAME
                                      : sps_pkg::SPS_SHIFT;
            end else if (run & ~cfg_in.master & sel_ok & ~r_q.ovf) begin
               if (tx_valid & ~r_q.loaded) begin
                  r_d.sr = tx_data;
                  tx_pop = 1'b1;
                  r_d.loaded = 1'b1;
               end
               if (cfg_in.frm_en & cfg_in.frm_in) begin
                  if (slave_select_n_pin_in & rx_edge)
                     r_d.st = sps_pkg::SPS_SHIFT;
               end else if (lead_edge | trail_edge) begin
                  r_d.st = sps_pkg::SPS_SHIFT;
                  if (rx_edge) begin
                     r_d.sr  = {r_d.sr[14:0], serial_in_pin_in};
                     r_d.cnt = 5'h01;
                  end
               end
            end
         end
         sps_pkg::SPS_FRAME: begin
            r_d.fs = 1'b1;
            if (tx_edge) r_d.st = sps_pkg::SPS_SHIFT;
         end
         sps_pkg::SPS_SHIFT: begin
            if (rx_edge) begin
               r_d.sr  = shifted;
               r_d.cnt = r_q.cnt + 5'h01;
               if (last) begin
                  r_d.done = 1'b1;
                  fin = 1'b1;
                  r_d.st = sps_pkg::SPS_IDLE;
                  r_d.loaded = 1'b0;
                  if (r_d.rx_full) begin
                     r_d.ovf = 1'b1;
                  end else begin
                     r_d.rxb = r_q.width ? shifted
                               : {8'h00, shifted[7:0]};
                     r_d.rx_full = 1'b1;
                  end
                  if (tx_valid & ~cfg_in.master) begin
                     r_d.sr = tx_data;
                     tx_pop = 1'b1;
                     r_d.loaded = 1'b1;
                  end
               end
            end
            if (tx_edge & (r_q.cnt != sps_pkg::CNT_ZERO)) begin
               r_d.sdo = msb;
            end
         end
         default: r_d.st = sps_pkg::SPS_IDLE;
      endcase
      // last bit stays on the pin through the final capture edge
      if (r_q.st == sps_pkg::SPS_IDLE)
         r_d.sdo = r_d.width ? r_d.sr[15] : r_d.sr[7];
      // select high or port halted: abort and restart at the msb
      if (~run | (~cfg_in.master & ~sel_ok) | r_q.ovf) begin
         if (~r_q.ovf | ~run | ~sel_ok) begin
            r_d.st  = sps_pkg::SPS_IDLE;
            r_d.cnt = sps_pkg::CNT_ZERO;
            r_d.div = sps_pkg::DIV_RST;
            r_d.sck = cfg_in.clock_idle_polarity;
         end
      end
      if (clr_ovf_in & ~(r_d.ovf & ~r_q.ovf)) r_d.ovf = r_d.ovf & ~r_q.ovf;
      // a completion in the same cycle wins over the clear
      if (clr_done_in & ~fin) r_d.done = 1'b0;
      if (r_q.width != cfg_in.word16) begin
         r_d.width = cfg_in.word16;
         r_d.st = sps_pkg::SPS_IDLE;
         r_d.cnt = sps_pkg::CNT_ZERO;
         r_d.rx_full = 1'b0;
         r_d.loaded = 1'b0;
      end
      r_d.irq = r_q.done & xfer_irq_enable_in;
      r_d.sck_oe_n = ~(cfg_in.enable & cfg_in.master);
      r_d.sdo_oe_n = ~(cfg_in.enable & ~cfg_in.out_dis & run
                       & (cfg_in.master | ~cfg_in.ss_en
                          | cfg_in.frm_en | ~slave_select_n_pin_in));
      r_d.fs_oe_n = ~(cfg_in.enable & cfg_in.frm_en
                      & ~cfg_in.frm_in);
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         r_q <= '0;
         r_q.st <= sps_pkg::SPS_IDLE;
         r_q.ss_in <= 1'b1;
         r_q.sdo_oe_n <= 1'b1;
         r_q.sck_oe_n <= 1'b1;
         r_q.fs_oe_n <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign buf_rdata_out             = r_q.rxb;
   assign stat_out.xfer_done        = r_q.done;
   assign stat_out.overflow         = r_q.ovf;
   assign stat_out.tx_full          = ~buf_wr_ready_out;
   assign stat_out.rx_full          = r_q.rx_full;
   assign stat_out.irq              = r_q.irq;
   assign shift_clock_pin_out       = r_q.sck;
   assign shift_clock_pin_oe_n_out  = r_q.sck_oe_n;
   assign serial_out_pin_out        = r_q.sdo;
   assign serial_out_pin_oe_n_out   = r_q.sdo_oe_n;
   assign slave_select_n_pin_out    = r_q.fs;
   assign slave_select_n_pin_oe_n_out = r_q.fs_oe_n;
endmodule : sps_port

// file: sps_port_properties.sv
// assertion checker bound to the serial port top module
`timescale 1ns/1ns
module sps_port_chk (
   input wire logic               core_clk_in,
   input wire logic               nrst_in,
   input wire sps_pkg::sps_cfg_t  cfg_in,
   input wire logic               xfer_irq_enable_in,
   input wire logic               sleep_in,
   input wire logic               buf_rd_in,
   input wire logic [15:0]        buf_rdata_out,
   input wire logic               clr_done_in,
   input wire logic               clr_ovf_in,
   input wire sps_pkg::sps_stat_t stat_out,
   input wire logic               shift_clock_pin_out,
   input wire logic               serial_out_pin_oe_n_out,
   input wire logic               slave_select_n_pin_in
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_ovf_held;
      stat_out.overflow [*8];
   endsequence
   sequence s_sel_off;
      (slave_select_n_pin_in && cfg_in.ss_en && !cfg_in.master) [*4];
   endsequence
   sequence s_asleep;
      sleep_in [*3];
   endsequence
   a_irq_tracks_done: assert property (
      stat_out.irq == $past(stat_out.xfer_done && xfer_irq_enable_in)
   ) else $error("irq does not follow done flag");
   a_done_stays_set: assert property (
      stat_out.xfer_done && !clr_done_in && $stable(cfg_in.word16)
      |=> stat_out.xfer_done
   ) else $error("done flag dropped by itself");
   a_ovf_stays_set: assert property (
      stat_out.overflow && !clr_ovf_in && !buf_rd_in
      && $stable(cfg_in.word16) |=> stat_out.overflow
   ) else $error("overflow dropped without read");
   a_rx_full_holds: assert property (
      stat_out.rx_full && !buf_rd_in && $stable(cfg_in.word16)
      |=> stat_out.rx_full
   ) else $error("receive full dropped without read");
   a_done_has_word: assert property (
      $rose(stat_out.xfer_done) |-> stat_out.rx_full || stat_out.overflow
   ) else $error("done without a held word");
   a_ovf_keeps_buf: assert property (
      $rose(stat_out.overflow) |-> $stable(buf_rdata_out)
   ) else $error("overflowing word reached the buffer");
   a_ovf_freezes_clk: assert property (
      s_ovf_held |-> $stable(shift_clock_pin_out)
   ) else $error("shift clock moves during overflow");
   a_out_dis_float: assert property (
      cfg_in.out_dis && $past(cfg_in.out_dis) |-> serial_out_pin_oe_n_out
   ) else $error("serial output driven while disabled");
   a_sel_high_float: assert property (
      s_sel_off |-> serial_out_pin_oe_n_out
   ) else $error("serial output driven with select high");
   a_sleep_no_clk: assert property (
      s_asleep |-> $stable(shift_clock_pin_out)
   ) else $error("shift clock moves in sleep");
endmodule : sps_port_chk
bind sps_port sps_port_chk u_chk (.*);

// file: sps_peer.sv
// serial slave model answering the port when it is master
`timescale 1ns/1ns
module sps_peer (
   input  wire logic        core_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        sck_in,
   input  wire logic        mosi_in,
   input  wire logic        word16_in,
   input  wire logic [15:0] reply_in,
   output logic             miso_out,
   output logic [15:0]      rx_word_out,
   output int               words_out
);
   logic        sck_q;
   logic [15:0] sh_q;
   logic [15:0] rx_q;
   int          cnt_q;
   assign miso_out = word16_in ? sh_q[15] : sh_q[7];
   always_ff @(posedge core_clk_in) begin
      sck_q <= sck_in;
      if (!nrst_in) begin
         cnt_q <= 0;
         words_out <= 0;
         sh_q <= reply_in;
         rx_q <= 16'h0000;
      end else if (sck_in && !sck_q) begin
         // capture on the rising edge, word ends after 8 or 16 bits
         rx_q <= {rx_q[14:0], mosi_in};
         cnt_q <= cnt_q + 1;
         if (cnt_q == (word16_in ? 15 : 7)) begin
            rx_word_out <= word16_in ? {rx_q[14:0], mosi_in}
                                     : {8'h00, rx_q[6:0], mosi_in};
            cnt_q <= 0;
            words_out <= words_out + 1;
         end
      end else if (!sck_in && sck_q) begin
         sh_q <= (cnt_q == 0) ? reply_in : sh_q << 1;
      end
   end
endmodule : sps_peer

// file: sps_port_tb_top.sv
// self-checking bench for the serial port with a slave model
`timescale 1ns/1ns
module sps_port_tb_top;
   logic               core_clk_in, nrst_in, irq_en, sleep, idle, wr;
   logic               rd, clr_d, clr_o, sel_n, sck_in, wr_rdy, sck;
   logic               sck_oe_n, mosi, mosi_oe_n, miso, fs, fs_oe_n;
   logic [15:0]        wdata, rdata, peer_rx;
   sps_pkg::sps_cfg_t  cfg;
   sps_pkg::sps_stat_t stat;
   int                 peer_words, miscompares, n_compared, k, seed, len;
   logic [15:0]        q[$];
   sps_port uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .cfg_in(cfg), .xfer_irq_enable_in(irq_en), .sleep_in(sleep),
      .cpu_idle_in(idle), .buf_wr_in(wr), .buf_wdata_in(wdata),
      .buf_wr_ready_out(wr_rdy), .buf_rd_in(rd), .buf_rdata_out(rdata),
      .clr_done_in(clr_d), .clr_ovf_in(clr_o), .stat_out(stat),
      .shift_clock_pin_in(sck_in), .shift_clock_pin_out(sck),
      .shift_clock_pin_oe_n_out(sck_oe_n), .serial_in_pin_in(miso),
      .serial_out_pin_out(mosi), .serial_out_pin_oe_n_out(mosi_oe_n),
      .slave_select_n_pin_in(sel_n), .slave_select_n_pin_out(fs),
      .slave_select_n_pin_oe_n_out(fs_oe_n));
   sps_peer peer (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .sck_in(sck), .mosi_in(mosi), .word16_in(cfg.word16),
      .reply_in(reply(peer_words)), .miso_out(miso),
      .rx_word_out(peer_rx), .words_out(peer_words));
   function automatic logic [15:0] reply(input int n);
      return 16'(n) * 16'h1357 ^ 16'hA5C3;
   endfunction : reply
   // one shift clock period in core cycles: four, primary, secondary
   function automatic int sck_period(input sps_pkg::sps_cfg_t c);
      return 4 * (64 >> (2 * int'(c.pri_pre))) * (8 - int'(c.sec_pre));
   endfunction : sck_period
   function automatic logic [15:0] fit(input logic [15:0] w);
      return cfg.word16 ? w : {8'h00, w[7:0]};
   endfunction : fit
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask : pulse
   task automatic wait_flag(input bit ovf);
      for (int n = 0; n < 4000; n++) begin
         if ((ovf ? stat.overflow : stat.xfer_done) === 1'b1) break;
         tick(1);
      end
      chk(16'(ovf ? stat.overflow : stat.xfer_done), 16'h0001);
   endtask : wait_flag
   task automatic give_verdict;
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   initial begin
      #800000;
      miscompares++;
      give_verdict();
   end
   initial begin
      {nrst_in, irq_en, sleep, idle, wr, rd, clr_d, clr_o, sck_in} = '0;
      sel_n = 1'b1;
      wdata = 16'h0000;
      cfg = '0;
      {miscompares, n_compared, k} = '0;
      seed = 32'hb5a5;
      tick(20);
      nrst_in = 1'b1;
      tick(1);
      chk(16'(stat), 16'h0000);
      chk(16'(mosi_oe_n), 16'h0001);
      for (int m = 0; m < 2; m++) begin
         // width changes only while the port is off
         cfg = '0;
         cfg.master = 1'b1;
         cfg.word16 = m[0];
         cfg.cke = 1'b1;
         cfg.pri_pre = 2'h3;
         cfg.sec_pre = 3'h6 + 3'($random(seed) & 1);
         tick(2);
         q.delete();
         wr = 1'b1;
         for (int i = 0; i < 12; i++) begin
            wdata = 16'($random(seed));
            if (wr_rdy === 1'b1) q.push_back(wdata);
            tick(1);
         end
         wr = 1'b0;
         chk(16'(q.size()), 16'(sps_pkg::FIFO_DEPTH));
         chk(16'(stat.tx_full), 16'h0001);
         cfg.enable = 1'b1;
         foreach (q[i]) begin
            irq_en = 1'($random(seed));
            idle = 1'($random(seed));
            wait_flag(1'b0);
            tick(2);
            chk(peer_rx, fit(q[i]));
            chk(rdata, fit(reply(k)));
            chk(16'(stat.irq), 16'(irq_en));
            pulse(rd);
            pulse(clr_d);
            k++;
         end
         cfg.enable = 1'b0;
         idle = 1'b0;
         tick(4);
      end
      wr = 1'b1;
      wdata = 16'($random(seed));
      tick(1);
      wdata = 16'($random(seed));
      tick(1);
      wr = 1'b0;
      cfg.enable = 1'b1;
      wait_flag(1'b1);
      tick(5);
      chk(rdata, reply(k));
      chk(16'(stat.xfer_done), 16'h0001);
      k += 2;
      pulse(clr_o);
      pulse(rd);
      tick(1);
      chk(16'({stat.overflow, stat.rx_full}), 16'h0000);
      pulse(clr_d);
      // stop in idle: a queued word must wait until idle ends
      cfg.stop_idle = 1'b1;
      idle = 1'b1;
      wdata = 16'($random(seed));
      pulse(wr);
      tick(200);
      chk(16'(stat.xfer_done), 16'h0000);
      idle = 1'b0;
      wait_flag(1'b0);
      tick(2);
      chk(peer_rx, wdata);
      chk(rdata, reply(k));
      pulse(rd);
      pulse(clr_d);
      // framed transfer: the sync pulse spans one shift clock period
      cfg.frm_en = 1'b1;
      pulse(wr);
      chk(16'(fs_oe_n), 16'h0000);
      for (len = 0; len < 200 && fs !== 1'b1; len++) tick(1);
      for (len = 0; len < 200 && fs === 1'b1; len++) tick(1);
      chk(16'(len), 16'(sck_period(cfg)));
      wait_flag(1'b0);
      pulse(rd);
      pulse(clr_d);
      cfg.frm_en = 1'b0;
      cfg.out_dis = 1'b1;
      tick(4);
      chk(16'(mosi_oe_n), 16'h0001);
      chk(16'(sck_oe_n), 16'h0000);
      cfg.clock_idle_polarity = 1'b1;
      tick(4);
      chk(16'(sck), 16'h0001);
      sleep = 1'b1;
      tick(4);
      sleep = 1'b0;
      cfg.out_dis = 1'b0;
      cfg.master = 1'b0;
      cfg.ss_en = 1'b1;
      tick(6);
      chk(16'(mosi_oe_n), 16'h0001);
      chk(16'(sck_oe_n), 16'h0001);
      give_verdict();
   end
endmodule : sps_port_tb_top
